// ---- clock_stop_power_gating_test.sv ----
/*
 * Self-checking bench for the clock stop and power gating block.
 * Assumes a short stabilisation wait parameter and the system logic model.
 */
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin err_count++; \
    $display("Error t=%0t got %h exp %h", $time, a, e); end end
module clock_stop_power_gating_test;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int STABLE = 16;
    logic ref_clk, rst, power_down_n, req_proc_halt, req_bus_halt, proc_halt_n, bus_halt_n;
    logic proc_clock, fixed_sixty_six_clock, bus_clock_gated, bus_clock_free, ref_clock;
    logic half_rate_processor_clock, interrupt_controller_clock, usb_rate_clock;
    logic osc_enable, synth_enable;
    logic [7:0] mv, hi;
    int err_count, n_tests, hi_run;
    wire [7:0] clks = {proc_clock, fixed_sixty_six_clock, bus_clock_gated, bus_clock_free,
        half_rate_processor_clock, interrupt_controller_clock, ref_clock, usb_rate_clock};
    // ****************************************
    // Instances
    // ****************************************
    cspg_clock_stop #(.STABLE_CYCLES(STABLE)) cspg_clock_stop_i (.ref_clk(ref_clk), .rst(rst),
        .proc_halt_n(proc_halt_n), .bus_halt_n(bus_halt_n), .power_down_n(power_down_n),
        .proc_clock(proc_clock), .fixed_sixty_six_clock(fixed_sixty_six_clock),
        .bus_clock_gated(bus_clock_gated), .bus_clock_free(bus_clock_free),
        .half_rate_processor_clock(half_rate_processor_clock), .ref_clock(ref_clock),
        .interrupt_controller_clock(interrupt_controller_clock),
        .usb_rate_clock(usb_rate_clock), .osc_enable(osc_enable), .synth_enable(synth_enable));
    cspg_sys_ctrl cspg_sys_ctrl_i (.bus_clock_free(bus_clock_free), .rst(rst),
        .req_proc_halt(req_proc_halt), .req_bus_halt(req_bus_halt),
        .proc_halt_n(proc_halt_n), .bus_halt_n(bus_halt_n));
    // ****************************************
    // Helpers
    // ****************************************
    initial begin
        ref_clk = 1'h0;
        forever #20 ref_clk = ~ref_clk;
    end
    // Sixty-six clock high pulses must be whole
    always @(posedge ref_clk) begin
        if (fixed_sixty_six_clock === 1'h1) begin
            hi_run = hi_run + 1;
        end else begin
            if (hi_run != 0 && osc_enable === 1'h1) `CHK(hi_run, 32'h2)
            hi_run = 0;
        end
    end
    task automatic tick(int n);
        repeat (n) begin
            @(posedge ref_clk);
            #1;
        end
    endtask
    task automatic watch(int n);
        logic [7:0] prev;
        mv = 8'h00;
        hi = 8'h00;
        prev = clks;
        repeat (n) begin
            tick(1);
            mv = mv | (clks ^ prev);
            hi = hi | clks;
            prev = clks;
        end
    endtask
    task automatic wait_hi(ref logic s, input int lim);
        int cnt;
        cnt = 0;
        while (s !== 1'h1 && cnt < lim) begin
            tick(1);
            cnt++;
        end
        `CHK(cnt < lim, 1'h1)
    endtask
    task automatic tally_and_finish;
        $display("Mismatches %0d of %0d checks", err_count, n_tests);
        if (err_count == 0 && n_tests > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_power_up;
        int cnt;
        cnt = 0;
        while (osc_enable !== 1'h1 && cnt < 10) begin
            tick(1);
            cnt++;
        end
        `CHK({cnt <= 4, synth_enable}, 2'h3)
        cnt = 0;
        while (clks === 8'h00 && cnt < 60) begin
            tick(1);
            cnt++;
        end
        `CHK(cnt >= STABLE - 1 && cnt <= STABLE + 4, 1'h1)
        watch(40);
        `CHK({mv, hi}, 16'hffff)
    endtask
    task automatic t_proc_halt;
        req_proc_halt = 1'h1;
        tick(20);
        watch(48);
        `CHK({mv, hi}, 16'h3f3f)
        req_proc_halt = 1'h0;
        wait_hi(proc_clock, 18);
    endtask
    task automatic t_bus_halt;
        req_bus_halt = 1'h1;
        tick(20);
        watch(48);
        `CHK({mv, hi}, 16'hdfdf)
        req_bus_halt = 1'h0;
        wait_hi(bus_clock_gated, 20);
    endtask
    task automatic t_power_down;
        power_down_n = 1'h0;
        tick(3);
        `CHK({clks, osc_enable, synth_enable}, 10'h000)
        watch(40);
        `CHK({mv, hi}, 16'h0000)
        power_down_n = 1'h1;
        t_power_up();
    endtask
    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        rst = 1'h1;
        power_down_n = 1'h1;
        req_proc_halt = 1'h0;
        req_bus_halt = 1'h0;
        err_count = 0;
        n_tests = 0;
        hi_run = 0;
        tick(12);
        rst = 1'h0;
        t_power_up();
        t_proc_halt();
        t_bus_halt();
        t_power_down();
        tally_and_finish();
    end
    initial begin
        #100000;
        err_count++;
        tally_and_finish();
    end
endmodule

// ---- cspg_clock_stop.sv ----
/*
 * Clock stop and power gating for the output clock groups.
 * Assumes halt inputs change in step with bus_clock_free and power_down_n is
 * fully asynchronous; each of the three pins is brought in through two flip-flops.
 */
// Overview of operation
// RULE_01: Latency counted in rising edges of free-running bus clock, input change to output.
// RULE_02: Halt inputs stop or restart their group within one bus clock edge.
// RULE_03: After power-down release, wait up to 3 ms before first valid clocks.
// RULE_04: Power-down low forces every output low within two bus clock edges.
// RULE_05: Disabled clock outputs sit at static low level.
// RULE_06: Processor halt stops processor and sixty-six clocks without runt pulses.
// RULE_07: Half-rate, interrupt, reference and usb clocks ignore processor halt.
// RULE_08: Bus halt leaves every clock except gated bus clocks undisturbed.
// RULE_09: System logic changes processor halt synchronously to free bus clock.
// RULE_10: System logic changes bus halt synchronously to free bus clock.
// RULE_11: Power-down is asynchronous and synchronised before use.
// RULE_12: Stop and start decisions are timed from the processor clock.
// RULE_13: System may halt groups independently or power down the whole device.
// RULE_14: Oscillator and synthesizer off during power-down, restarted on release.
// RULE_15: Free-running bus clock is never gated by bus halt.
module cspg_clock_stop #(
    parameter int STABLE_CYCLES = cspg_pkg::STABLE_CYC
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Power management pins
    input wire logic proc_halt_n,
    input wire logic bus_halt_n,
    input wire logic power_down_n,
    // Gated clock groups
    output logic proc_clock,
    output logic fixed_sixty_six_clock,
    output logic bus_clock_gated,
    // Free-running clocks
    output logic bus_clock_free,
    output logic half_rate_processor_clock,
    output logic interrupt_controller_clock,
    output logic ref_clock,
    output logic usb_rate_clock,
    // Analogue enables
    output logic osc_enable,
    output logic synth_enable
);

    // ****************************************
    // State
    // ****************************************
    typedef struct packed {
        logic pd_meta;
        logic pd_sync;
        logic ph_meta;
        logic ph_sync;
        logic bh_meta;
        logic bh_sync;
        cspg_pkg::cspg_state_t state;
        logic [cspg_pkg::WAIT_W-1:0] wait_cnt;
        logic [cspg_pkg::PHASE_W-1:0] phase;
        logic proc_en;
        logic sixty_en;
        logic bus_en;
        logic proc_o;
        logic sixty_o;
        logic busg_o;
        logic busf_o;
        logic half_o;
        logic intc_o;
        logic ref_o;
        logic usb_o;
        logic osc_o;
    } cspg_regs_t;

    localparam cspg_regs_t REGS_RST = '{
        pd_meta: 1'b0,
        pd_sync: 1'b0,
        ph_meta: 1'b0,
        ph_sync: 1'b0,
        bh_meta: 1'b0,
        bh_sync: 1'b0,
        state: cspg_pkg::ST_OFF,
        wait_cnt: cspg_pkg::WAIT_RST,
        phase: cspg_pkg::PHASE_RST,
        proc_en: 1'b0,
        sixty_en: 1'b0,
        bus_en: 1'b0,
        proc_o: 1'b0,
        sixty_o: 1'b0,
        busg_o: 1'b0,
        busf_o: 1'b0,
        half_o: 1'b0,
        intc_o: 1'b0,
        ref_o: 1'b0,
        usb_o: 1'b0,
        osc_o: 1'b0
    };

    localparam logic [cspg_pkg::WAIT_W-1:0] WAIT_LAST = cspg_pkg::WAIT_W'(STABLE_CYCLES - 1);

    cspg_regs_t s_reg;
    cspg_regs_t s_next;

    // ****************************************
    // Next state
    // ****************************************
    always_comb begin
        logic [cspg_pkg::PHASE_W-1:0] ph;
        logic run;
        ph = '0;
        run = 1'b0;
        s_next = s_reg;
        // Two-stage synchronisers
        s_next.pd_meta = power_down_n;
        s_next.pd_sync = s_reg.pd_meta; // [RULE_11]
        s_next.ph_meta = proc_halt_n;
        s_next.ph_sync = s_reg.ph_meta;
        s_next.bh_meta = bus_halt_n;
        s_next.bh_sync = s_reg.bh_meta;
        // Power sequencing
        case (s_reg.state)
            cspg_pkg::ST_OFF: begin
                s_next.wait_cnt = cspg_pkg::WAIT_RST;
                if (s_reg.pd_sync) begin
                    s_next.state = cspg_pkg::ST_WAIT; // [RULE_14]
                end
            end
            cspg_pkg::ST_WAIT: begin
                if (!s_reg.pd_sync) begin
                    s_next.state = cspg_pkg::ST_OFF;
                end else if (s_reg.wait_cnt == WAIT_LAST) begin
                    s_next.state = cspg_pkg::ST_RUN; // [RULE_03]
                end else begin
                    s_next.wait_cnt = s_reg.wait_cnt + 1'b1;
                end
            end
            cspg_pkg::ST_RUN: begin
                if (!s_reg.pd_sync) begin
                    s_next.state = cspg_pkg::ST_OFF; // [RULE_04]
                end
            end
            default: begin
                s_next.state = cspg_pkg::ST_OFF;
            end
        endcase
        run = (s_next.state == cspg_pkg::ST_RUN);
        // Phase counter held at PHASE_RST while the oscillator is off
        if (s_next.state == cspg_pkg::ST_OFF) begin
            s_next.phase = cspg_pkg::PHASE_RST;
        end else begin
            s_next.phase = s_reg.phase + 1'b1;
        end
        ph = s_next.phase;
        // Enables only move while their clock is in its low half
        if (!ph[cspg_pkg::PROC_BIT]) begin
            s_next.proc_en = s_reg.ph_sync; // [RULE_12] [RULE_06] [RULE_02]
        end
        if (!ph[cspg_pkg::SIXTY_BIT]) begin
            s_next.sixty_en = s_reg.ph_sync; // [RULE_06] [RULE_12]
        end
        if (!ph[cspg_pkg::BUS_BIT]) begin
            s_next.bus_en = s_reg.bh_sync; // [RULE_02] [RULE_01]
        end
        // Outputs held low when disabled
        s_next.proc_o = run & s_next.proc_en & ph[cspg_pkg::PROC_BIT]; // [RULE_05]
        s_next.sixty_o = run & s_next.sixty_en & ph[cspg_pkg::SIXTY_BIT];
        s_next.busg_o = run & s_next.bus_en & ph[cspg_pkg::BUS_BIT]; // [RULE_08]
        s_next.busf_o = run & ph[cspg_pkg::BUS_BIT]; // [RULE_15]
        s_next.half_o = run & ph[cspg_pkg::HALF_BIT]; // [RULE_07]
        s_next.intc_o = run & ph[cspg_pkg::INTC_BIT];
        s_next.ref_o = run & ph[cspg_pkg::REF_BIT];
        s_next.usb_o = run & ph[cspg_pkg::USB_BIT];
        s_next.osc_o = (s_next.state != cspg_pkg::ST_OFF); // [RULE_14]
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            s_reg <= REGS_RST;
        end else begin
            s_reg <= s_next;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    assign proc_clock = s_reg.proc_o;
    assign fixed_sixty_six_clock = s_reg.sixty_o;
    assign bus_clock_gated = s_reg.busg_o;
    assign bus_clock_free = s_reg.busf_o;
    assign half_rate_processor_clock = s_reg.half_o;
    assign interrupt_controller_clock = s_reg.intc_o;
    assign ref_clock = s_reg.ref_o;
    assign usb_rate_clock = s_reg.usb_o;
    assign osc_enable = s_reg.osc_o;
    assign synth_enable = s_reg.osc_o;

    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    logic all_low;
    assign all_low = !(proc_clock | fixed_sixty_six_clock | bus_clock_gated | bus_clock_free
        | half_rate_processor_clock | interrupt_controller_clock | ref_clock | usb_rate_clock);

    a_pd_all_low: assert property ( // [RULE_04]
        $fell(power_down_n) |-> ##[1:4] (all_low && !osc_enable))
        else $error("outputs not low after power-down");

    a_pd_stays_low: assert property ( // [RULE_05]
        !s_reg.pd_sync |=> all_low)
        else $error("output toggles during power-down");

    a_osc_off_pd: assert property ( // [RULE_14]
        $rose(s_reg.pd_sync) && s_reg.state == cspg_pkg::ST_OFF |=> osc_enable && synth_enable)
        else $error("oscillator not restarted");

    a_wait_no_clock: assert property ( // [RULE_03]
        s_reg.state == cspg_pkg::ST_WAIT |-> all_low)
        else $error("clock driven before stable");

    a_proc_stop: assert property ( // [RULE_02]
        (!proc_halt_n && s_reg.state == cspg_pkg::ST_RUN)[*4] |-> ##[0:4] !proc_clock[*2])
        else $error("processor clock not stopped");

    a_proc_no_runt: assert property ( // [RULE_06]
        $rose(proc_clock) |=> $fell(proc_clock) || s_reg.state != cspg_pkg::ST_RUN)
        else $error("processor clock runt");

    a_sixty_no_runt: assert property ( // [RULE_06]
        $rose(fixed_sixty_six_clock) |=> fixed_sixty_six_clock
            || s_reg.state != cspg_pkg::ST_RUN)
        else $error("sixty-six clock runt");

    a_free_ignores: assert property ( // [RULE_15]
        s_reg.state == cspg_pkg::ST_RUN && $past(s_reg.state) == cspg_pkg::ST_RUN
            |-> bus_clock_free == s_reg.phase[cspg_pkg::BUS_BIT]
            && half_rate_processor_clock == s_reg.phase[cspg_pkg::HALF_BIT])
        else $error("free clock disturbed");

    a_bus_stop: assert property ( // [RULE_08]
        (!bus_halt_n && s_reg.state == cspg_pkg::ST_RUN)[*8] |-> !bus_clock_gated)
        else $error("gated bus clock not stopped");

    a_proc_restart: assert property ( // [RULE_02]
        (proc_halt_n && s_reg.state == cspg_pkg::ST_RUN)[*4]
            |-> ##[0:4] (proc_clock || !proc_halt_n || s_reg.state != cspg_pkg::ST_RUN))
        else $error("processor clock not restarted");

    a_bus_restart: assert property ( // [RULE_02]
        (bus_halt_n && s_reg.state == cspg_pkg::ST_RUN)[*8]
            |-> ##[0:8] (bus_clock_gated || !bus_halt_n || s_reg.state != cspg_pkg::ST_RUN))
        else $error("gated bus clock not restarted");

    a_proc_en_low: assert property ( // [RULE_12]
        $changed(s_reg.proc_en) |-> !s_reg.phase[cspg_pkg::PROC_BIT])
        else $error("processor enable moved in high phase");

    a_sixty_en_low: assert property ( // [RULE_06]
        $changed(s_reg.sixty_en) |-> !s_reg.phase[cspg_pkg::SIXTY_BIT])
        else $error("sixty-six enable moved in high phase");

    a_bus_en_low: assert property ( // [RULE_01]
        $changed(s_reg.bus_en) |-> !s_reg.phase[cspg_pkg::BUS_BIT])
        else $error("bus enable moved in high phase");

    a_free_groups: assert property ( // [RULE_07]
        s_reg.state == cspg_pkg::ST_RUN |-> usb_rate_clock == s_reg.phase[cspg_pkg::USB_BIT]
            && ref_clock == s_reg.phase[cspg_pkg::REF_BIT]
            && interrupt_controller_clock == s_reg.phase[cspg_pkg::INTC_BIT])
        else $error("free clock group disturbed");

    a_pd_to_off: assert property ( // [RULE_11]
        !s_reg.pd_sync |=> s_reg.state == cspg_pkg::ST_OFF)
        else $error("power-down not taken");

    a_off_no_osc: assert property ( // [RULE_14]
        s_reg.state == cspg_pkg::ST_OFF |-> !osc_enable && !synth_enable)
        else $error("oscillator running in power-down");

    a_off_phase: assert property ( // [RULE_14]
        s_reg.state == cspg_pkg::ST_OFF |-> s_reg.phase == cspg_pkg::PHASE_RST)
        else $error("phase counter running in power-down");

    a_run_from_wait: assert property ( // [RULE_03]
        s_reg.state == cspg_pkg::ST_RUN && $past(s_reg.state) != cspg_pkg::ST_RUN
            |-> $past(s_reg.state) == cspg_pkg::ST_WAIT)
        else $error("run entered without wait");

    // ****************************************
    // Coverage
    // ****************************************
    c_power_up: cover property (s_reg.state == cspg_pkg::ST_WAIT
        ##1 s_reg.state == cspg_pkg::ST_RUN);
    c_proc_halt: cover property ($fell(proc_clock) ##1 !s_reg.proc_en);
    c_bus_halt: cover property (bus_clock_free && !bus_halt_n && !bus_clock_gated);
    c_power_down: cover property (s_reg.state == cspg_pkg::ST_RUN
        ##1 s_reg.state == cspg_pkg::ST_OFF);

endmodule

// ---- cspg_pkg.sv ----
/*
 * Constants for the clock stop and power gating block: phase counter layout,
 * state codes and the power-up stabilisation time.
 * Assumes a single 25 MHz reference clock drives every register.
 */
package cspg_pkg;

    // ****************************************
    // Clock and timing
    // ****************************************
    localparam int REF_CLK_MHZ = 25;
    localparam int STABLE_TIME_US = 3000;
    // Longest wait, exactly 3 ms of reference cycles
    localparam int STABLE_CYC = STABLE_TIME_US * REF_CLK_MHZ;
    localparam int WAIT_W = 17;

    // ****************************************
    // Phase counter layout
    // ****************************************
    localparam int PHASE_W = 4;
    localparam int PROC_BIT = 0;
    localparam int SIXTY_BIT = 1;
    localparam int HALF_BIT = 1;
    localparam int BUS_BIT = 2;
    localparam int INTC_BIT = 3;
    localparam int REF_BIT = 2;
    localparam int USB_BIT = 1;

    // ****************************************
    // Reset values
    // ****************************************
    localparam logic [PHASE_W-1:0] PHASE_RST = 4'h0;
    localparam logic [WAIT_W-1:0] WAIT_RST = 17'h00000;

    // ****************************************
    // Power states
    // ****************************************
    typedef enum logic [2:0] {
        ST_OFF  = 3'h1,
        ST_WAIT = 3'h2,
        ST_RUN  = 3'h4
    } cspg_state_t;

endpackage

// ---- cspg_sys_ctrl.sv ----
/*
 * System logic model that drives the two halt pins of the block.
 * Assumes bus_clock_free from the block; halt requests come from the bench.
 */
module cspg_sys_ctrl (
    // Clock and reset
    input wire logic bus_clock_free,
    input wire logic rst,
    // Requests from the bench
    input wire logic req_proc_halt,
    input wire logic req_bus_halt,
    // Halt pins
    output logic proc_halt_n,
    output logic bus_halt_n
);
    timeunit 1ns;
    timeprecision 1ps;
    // Pins change only just after free bus clock rising edges
    always_ff @(posedge bus_clock_free or posedge rst) begin
        if (rst) begin
            proc_halt_n <= 1'h1;
            bus_halt_n <= 1'h1;
        end else begin
            proc_halt_n <= #1 ~req_proc_halt;
            bus_halt_n <= #1 ~req_bus_halt;
        end
    end
endmodule
